// ==== core/ccrf_core.sv ====
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`include "ccrf_cfg.svh"
// ==========================================
// Dedicated registers, status word and interrupt gate
module ccrf_core
	import ccrf_pkg::*;
#(
	parameter logic [15:0] IO_TOP = `CCRF_IO_TOP,
	parameter logic [15:0] PROG_BASE = `CCRF_PROG_BASE,
	parameter logic [15:0] BANK_BASE = `CCRF_BANK_BASE
)(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Software register port
	input wire logic [3:0] sw_addr_i,
	input wire logic [15:0] sw_wdata_i,
	input wire logic sw_wr_i,
	input wire logic sw_rd_i,
	output logic [15:0] sw_rdata_o,
	// Sequencer controls
	input wire ccrf_wr_s seq_wr_i,
	input wire ccrf_alu_req_s alu_req_i,
	input wire logic pc_inc_i,
	input wire logic sp_push_i,
	input wire logic sp_pop_i,
	// Address helpers
	input wire logic gpr_req_i,
	input wire logic [2:0] gpr_num_i,
	input wire logic [7:0] disp_i,
	// Interrupt gate
	input wire ccrf_irq_s irq_i,
	output logic irq_take_o,
	// Register contents
	output logic [15:0] ip_o,
	output logic [15:0] acc_o,
	output logic [15:0] tmp_o,
	output logic [15:0] index_reg_o,
	output logic [15:0] extra_mem_pointer_o,
	output logic [15:0] stack_top_pointer_o,
	output ccrf_psw_s psw_o,
	// Formed addresses
	output logic [15:0] ea_index_o,
	output logic [15:0] gpr_addr_o,
	output ccrf_area_e fetch_area_o
);
	// ==========================================
	// Helper functions

	// A register is written by the sequencer or by software this cycle
	function automatic logic hit(input ccrf_wr_s w, input logic swe, input logic [3:0] a, input ccrf_sel_e s);
		hit = (w.we && (w.sel == s)) || (swe && (a == {1'b0, s}));
	endfunction

	// Sequencer data wins over software data on a shared cycle
	function automatic logic [15:0] wval(input ccrf_wr_s w, input logic [15:0] swd, input ccrf_sel_e s);
		wval = (w.we && (w.sel == s)) ? w.data : swd;
	endfunction

	// Area of an address in the single 64 KB space
	function automatic ccrf_area_e area_of(input logic [15:0] a);
		if (a <= IO_TOP) begin
			area_of = CCRF_AREA_IO;
		end else if (a < PROG_BASE) begin
			area_of = CCRF_AREA_DATA;
		end else begin
			area_of = CCRF_AREA_PROG;
		end
	endfunction

	// ==========================================
	// Storage

	logic [15:0] pc_r; // Instruction pointer
	logic [15:0] acc_r; // Accumulator
	logic [15:0] tmp_r; // Temporary accumulator
	logic [15:0] index_r; // Index register
	logic [15:0] xptr_r; // Extra memory pointer
	logic [15:0] sp_r; // Stack top pointer
	logic [7:0] bank_r; // Bank select pointer
	ccrf_cc_s cc_r; // Condition code byte
	logic [15:0] rdata_r; // Read data, one cycle after the strobe
	logic [15:0] ea_index_r; // Indexed operand address
	logic [15:0] gpr_addr_r; // Banked register address
	ccrf_area_e area_r; // Area of the fetch address
	logic [15:0] alu_res; // Result from the arithmetic unit
	ccrf_cc_s alu_cc; // Flags from the arithmetic unit
	logic alu_wr; // Operation writes the accumulator
	logic [15:0] disp_ext; // Sign-extended displacement
	logic psw_hit; // Status word written by a port this cycle

	assign disp_ext = {{8{disp_i[7]}}, disp_i};
	assign psw_hit = hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_PSW);

	// ==========================================
	// Arithmetic unit

	ccrf_alu u_alu (
		.op_i(alu_req_i.go ? alu_req_i.op : CCRF_OP_NONE),
		.word_i(alu_req_i.word),
		.acc_i(acc_r),
		.tmp_i(tmp_r),
		.cc_i(cc_r),
		.res_o(alu_res),
		.cc_o(alu_cc),
		.wr_acc_o(alu_wr)
	);

	// ==========================================
	// Assertion defaults

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// Byte operation that writes the accumulator
	sequence s_byte_wr;
		alu_req_i.go && !alu_req_i.word && alu_wr;
	endsequence
	// Byte add without carry in
	sequence s_byte_add;
		alu_req_i.go && !alu_req_i.word && (alu_req_i.op == CCRF_OP_ADD);
	endsequence
	// Byte rotate left through carry
	sequence s_byte_rolc;
		alu_req_i.go && !alu_req_i.word && (alu_req_i.op == CCRF_OP_ROLC);
	endsequence

	// ==========================================
	// Instruction pointer

	// Loads win over the fetch step so a jump is never lost
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pc_r <= `CCRF_RST_PC;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_PC)) begin
			pc_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_PC);
		end else if (pc_inc_i) begin
			pc_r <= pc_r + 16'h0001;
		end
	end

	a_pc_step: assert property (pc_inc_i && !hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_PC)
		|=> pc_r == $past(pc_r) + 16'h0001) else $error("pointer did not step");

	// Area the fetch address falls in, one cycle behind the pointer
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			area_r <= CCRF_AREA_IO;
		end else begin
			area_r <= area_of(pc_r);
		end
	end

	// ==========================================
	// Accumulator and temporary accumulator

	// An operation result beats any port write in the same cycle
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			acc_r <= `CCRF_RST_WORD;
		end else if (alu_req_i.go && alu_wr) begin
			acc_r <= alu_res;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_ACC)) begin
			acc_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_ACC);
		end
	end

	a_acc_upper: assert property (s_byte_wr |=> acc_r[15:8] == $past(acc_r[15:8]))
		else $error("byte operation changed upper byte");
	a_tmp_operand: assert property (s_byte_add
		|=> acc_r[7:0] == $past(acc_r[7:0]) + $past(tmp_r[7:0])) else $error("byte sum wrong");

	// Second operand, written only by the ports
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tmp_r <= `CCRF_RST_WORD;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_TMP)) begin
			tmp_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_TMP);
		end
	end

	// ==========================================
	// Index register and extra pointer

	// Index register holds the base for indexed operands
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			index_r <= `CCRF_RST_WORD;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_INDEX)) begin
			index_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_INDEX);
		end
	end

	// Indexed address formed every cycle; wraps within 64 KB
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ea_index_r <= `CCRF_RST_WORD;
		end else begin
			ea_index_r <= index_r + disp_ext;
		end
	end

	a_index_add: assert property (1'b1 |=> ea_index_o == $past(index_r) + $past(disp_ext))
		else $error("indexed address wrong");

	// Extra pointer reaches any of the 64 KB
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xptr_r <= `CCRF_RST_WORD;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_XPTR)) begin
			xptr_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_XPTR);
		end
	end

	// ==========================================
	// Stack pointer

	// Push moves down, pop moves up; a load beats both
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sp_r <= `CCRF_RST_SP;
		end else if (hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_SP)) begin
			sp_r <= wval(seq_wr_i, sw_wdata_i, CCRF_SEL_SP);
		end else if (sp_push_i) begin
			sp_r <= sp_r - `CCRF_SP_STEP;
		end else if (sp_pop_i) begin
			sp_r <= sp_r + `CCRF_SP_STEP;
		end
	end

	a_sp_push: assert property (sp_push_i && !hit(seq_wr_i, sw_wr_i, sw_addr_i, CCRF_SEL_SP)
		|=> sp_r == $past(sp_r) - `CCRF_SP_STEP) else $error("push did not move stack");

	// ==========================================
	// Status word

	// Upper byte: bank select pointer
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bank_r <= 8'(`CCRF_RST_PSW >> 8);
		end else if (psw_hit) begin
			bank_r <= 8'(wval(seq_wr_i, sw_wdata_i, CCRF_SEL_PSW) >> 8);
		end
	end

	// Lower byte: flags; hardware results win over port writes
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cc_r <= ccrf_cc_s'(8'(`CCRF_RST_PSW));
		end else if (alu_req_i.go && (alu_req_i.op != CCRF_OP_NONE)) begin
			cc_r <= alu_cc;
		end else if (psw_hit) begin
			cc_r <= ccrf_cc_s'(8'(wval(seq_wr_i, sw_wdata_i, CCRF_SEL_PSW)));
		end
	end

	a_flags_hold: assert property (!alu_req_i.go && !psw_hit |=> $stable(cc_r))
		else $error("flags moved without cause");
	a_half_carry: assert property (s_byte_add
		|=> cc_r.h == (({1'b0, $past(acc_r[3:0])} + {1'b0, $past(tmp_r[3:0])}) >= 5'h10))
		else $error("half carry wrong");
	a_neg_flag: assert property (s_byte_wr |=> cc_r.n == acc_r[7])
		else $error("negative flag wrong");
	a_zero_flag: assert property (s_byte_wr |=> cc_r.z == (acc_r[7:0] == 8'h00))
		else $error("zero flag wrong");
	a_carry_out: assert property (s_byte_add
		|=> cc_r.c == (({1'b0, $past(acc_r[7:0])} + {1'b0, $past(tmp_r[7:0])}) >= 9'h100))
		else $error("carry flag wrong");
	a_shift_carry: assert property (s_byte_rolc |=> cc_r.c == $past(acc_r[7]))
		else $error("shift carry wrong");

	// ==========================================
	// Interrupt gate

	// Lower request code is higher priority; the all-ones mask admits none
	always_comb begin
		irq_take_o = irq_i.req && cc_r.ie && (irq_i.lvl < cc_r.mask) && (cc_r.mask != `CCRF_MASK_NONE);
	end

	a_irq_block: assert property (!cc_r.ie |-> !irq_take_o)
		else $error("interrupt taken while disabled");
	a_irq_level: assert property (irq_take_o |-> (irq_i.lvl < cc_r.mask) && (cc_r.mask != 2'h3))
		else $error("interrupt level not masked");

	// ==========================================
	// Banked register address

	// Eight bytes per bank; only 5 pointer bits reach the 32 banks
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			gpr_addr_r <= `CCRF_BANK_BASE;
		end else if (gpr_req_i) begin
			gpr_addr_r <= BANK_BASE + {8'h00, bank_r[4:0], gpr_num_i};
		end
	end

	a_gpr_addr: assert property (gpr_req_i
		|=> gpr_addr_o == BANK_BASE + {8'h00, $past(bank_r[4:0]), $past(gpr_num_i)})
		else $error("bank address wrong");

	// ==========================================
	// Software read port

	// Data stands only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_r <= 16'h0000;
		end else if (sw_rd_i) begin
			case (sw_addr_i)
				`CCRF_OFF_PC: rdata_r <= pc_r;
				`CCRF_OFF_ACC: rdata_r <= acc_r;
				`CCRF_OFF_TMP: rdata_r <= tmp_r;
				`CCRF_OFF_INDEX: rdata_r <= index_r;
				`CCRF_OFF_XPTR: rdata_r <= xptr_r;
				`CCRF_OFF_SP: rdata_r <= sp_r;
				`CCRF_OFF_PSW: rdata_r <= {bank_r, cc_r};
				default: rdata_r <= 16'h0000;
			endcase
		end else begin
			rdata_r <= 16'h0000;
		end
	end

	// ==========================================
	// Outputs, all from flip-flops except the interrupt handshake

	assign sw_rdata_o = rdata_r;
	assign ip_o = pc_r;
	assign acc_o = acc_r;
	assign tmp_o = tmp_r;
	assign index_reg_o = index_r;
	assign extra_mem_pointer_o = xptr_r;
	assign stack_top_pointer_o = sp_r;
	assign psw_o = {bank_r, cc_r};
	assign ea_index_o = ea_index_r;
	assign gpr_addr_o = gpr_addr_r;
	assign fetch_area_o = area_r;
endmodule

// ==== core/ccrf_cfg.svh ====
`ifndef CCRF_CFG_SVH
`define CCRF_CFG_SVH

// ==========================================
// Software port register indexes
`define CCRF_OFF_PC 4'h0
`define CCRF_OFF_ACC 4'h1
`define CCRF_OFF_TMP 4'h2
`define CCRF_OFF_INDEX 4'h3
`define CCRF_OFF_XPTR 4'h4
`define CCRF_OFF_SP 4'h5
`define CCRF_OFF_PSW 4'h6

// ==========================================
// Reset values
`define CCRF_RST_PC 16'h0000
`define CCRF_RST_WORD 16'h0000
`define CCRF_RST_SP 16'h0000
`define CCRF_RST_PSW 16'h0000

// ==========================================
// Memory map and stepping
`define CCRF_BANK_BASE 16'h0100
`define CCRF_IO_TOP 16'h007F
`define CCRF_PROG_BASE 16'h8000
`define CCRF_SP_STEP 16'h0001
`define CCRF_MASK_NONE 2'h3
`endif

// ==== core/ccrf_pkg.sv ====
// ==========================================
// Shared types of the register and flag block
package ccrf_pkg;
	// Operations driven by the sequencer
	typedef enum logic [3:0] {
		CCRF_OP_NONE = 4'h0,
		CCRF_OP_ADD = 4'h1,
		CCRF_OP_ADDC = 4'h2,
		CCRF_OP_SUB = 4'h3,
		CCRF_OP_SUBC = 4'h4,
		CCRF_OP_CMP = 4'h5,
		CCRF_OP_AND = 4'h6,
		CCRF_OP_OR = 4'h7,
		CCRF_OP_XOR = 4'h8,
		CCRF_OP_ROLC = 4'h9,
		CCRF_OP_RORC = 4'hA
	} ccrf_op_e;
	// Register selector, equal to the software index
	typedef enum logic [2:0] {
		CCRF_SEL_PC = 3'h0,
		CCRF_SEL_ACC = 3'h1,
		CCRF_SEL_TMP = 3'h2,
		CCRF_SEL_INDEX = 3'h3,
		CCRF_SEL_XPTR = 3'h4,
		CCRF_SEL_SP = 3'h5,
		CCRF_SEL_PSW = 3'h6
	} ccrf_sel_e;
	// Area of the address space
	typedef enum logic [1:0] {
		CCRF_AREA_IO = 2'h0,
		CCRF_AREA_DATA = 2'h1,
		CCRF_AREA_PROG = 2'h2
	} ccrf_area_e;
	// Condition code byte, bit 7 down to bit 0
	typedef struct packed {logic h; logic ie; logic [1:0] mask; logic n; logic z; logic v; logic c;} ccrf_cc_s;
	// Status word: bank select pointer above the condition code byte
	typedef struct packed {logic [7:0] bank; ccrf_cc_s cc;} ccrf_psw_s;
	typedef struct packed {logic go; ccrf_op_e op; logic word;} ccrf_alu_req_s;
	typedef struct packed {logic we; ccrf_sel_e sel; logic [15:0] data;} ccrf_wr_s;
	typedef struct packed {logic req; logic [1:0] lvl;} ccrf_irq_s;
endpackage

// ==== core/ccrf_alu.sv ====
`timescale 1ns/10ps
// ==========================================
// Arithmetic and condition-code unit
module ccrf_alu
	import ccrf_pkg::*;
(
	// Operation
	input wire ccrf_op_e op_i,
	input wire logic word_i,
	// Operands and incoming flags
	input wire logic [15:0] acc_i,
	input wire logic [15:0] tmp_i,
	input wire ccrf_cc_s cc_i,
	// Results
	output logic [15:0] res_o,
	output ccrf_cc_s cc_o,
	output logic wr_acc_o
);
	// Shared adder; subtraction arrives as inverted operand plus carry
	function automatic logic [16:0] add17(input logic [15:0] x, input logic [15:0] y, input logic ci);
		add17 = {1'b0, x} + {1'b0, y} + {16'h0000, ci};
	endfunction
	// Byte operations keep the upper accumulator byte untouched
	function automatic logic [15:0] merge(input logic w, input logic [15:0] a, input logic [15:0] v);
		merge = w ? v : {a[15:8], v[7:0]};
	endfunction

	logic sub_op; // Subtract-type operation
	logic arith; // Adder result selected
	logic cin; // Adder carry in
	logic msb_a; // Sign of first operand
	logic msb_b; // Sign of effective second operand
	logic msb_r; // Sign of result
	logic [15:0] ab; // Width-masked accumulator
	logic [15:0] bb; // Width-masked temporary, inverted for subtract
	logic [15:0] lg; // Logic or shift result
	logic [16:0] sum; // Full sum
	logic [16:0] half; // Low nibble sum

	// Result and flags for one operation
	always_comb begin
		sub_op = (op_i == CCRF_OP_SUB) || (op_i == CCRF_OP_SUBC) || (op_i == CCRF_OP_CMP);
		arith = sub_op || (op_i == CCRF_OP_ADD) || (op_i == CCRF_OP_ADDC);
		case (op_i)
			CCRF_OP_ADDC: cin = cc_i.c;
			CCRF_OP_SUB, CCRF_OP_CMP: cin = 1'b1;
			CCRF_OP_SUBC: cin = ~cc_i.c;
			default: cin = 1'b0;
		endcase
		ab = word_i ? acc_i : {8'h00, acc_i[7:0]};
		bb = word_i ? tmp_i : {8'h00, tmp_i[7:0]};
		if (sub_op) begin
			bb = word_i ? ~tmp_i : {8'h00, ~tmp_i[7:0]};
		end
		sum = add17(ab, bb, cin);
		half = add17({12'h000, ab[3:0]}, {12'h000, bb[3:0]}, cin);
		msb_a = word_i ? ab[15] : ab[7];
		msb_b = word_i ? bb[15] : bb[7];
		cc_o = cc_i;
		case (op_i)
			CCRF_OP_AND: lg = acc_i & tmp_i;
			CCRF_OP_OR: lg = acc_i | tmp_i;
			CCRF_OP_XOR: lg = acc_i ^ tmp_i;
			CCRF_OP_ROLC: lg = word_i ? {acc_i[14:0], cc_i.c} : {8'h00, acc_i[6:0], cc_i.c};
			CCRF_OP_RORC: lg = word_i ? {cc_i.c, acc_i[15:1]} : {8'h00, cc_i.c, acc_i[7:1]};
			default: lg = sum[15:0];
		endcase
		res_o = merge(word_i, acc_i, lg);
		wr_acc_o = (op_i != CCRF_OP_NONE) && (op_i != CCRF_OP_CMP);
		msb_r = word_i ? res_o[15] : res_o[7];
		if (op_i != CCRF_OP_NONE) begin
			cc_o.n = msb_r;
			cc_o.z = word_i ? (res_o == 16'h0000) : (res_o[7:0] == 8'h00);
		end
		if (arith) begin
			cc_o.h = half[4] ^ sub_op;
			cc_o.c = (word_i ? sum[16] : sum[8]) ^ sub_op;
			cc_o.v = (msb_a == msb_b) && (msb_r != msb_a);
		end else if ((op_i == CCRF_OP_AND) || (op_i == CCRF_OP_OR) || (op_i == CCRF_OP_XOR)) begin
			cc_o.v = 1'b0;
		end else if (op_i == CCRF_OP_ROLC) begin
			cc_o.c = word_i ? acc_i[15] : acc_i[7];
		end else if (op_i == CCRF_OP_RORC) begin
			cc_o.c = acc_i[0];
		end
	end
endmodule

// ==== bench/ccrf_seq_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Sequencer stand-in that drives the control side of the core
module ccrf_seq_model
	import ccrf_pkg::*;
(
	// Clock
	input wire logic ref_clk_i,
	// Sequencer controls
	output ccrf_wr_s seq_wr_o,
	output ccrf_alu_req_s alu_req_o,
	output logic pc_inc_o,
	output logic sp_push_o,
	output logic sp_pop_o,
	// Address helpers and interrupt request
	output logic gpr_req_o,
	output logic [2:0] gpr_num_o,
	output logic [7:0] disp_o,
	output ccrf_irq_s irq_o
);
	// Everything idle at time zero
	initial begin
		seq_wr_o = '0;
		alu_req_o = '0;
		pc_inc_o = 1'b0;
		sp_push_o = 1'b0;
		sp_pop_o = 1'b0;
		gpr_req_o = 1'b0;
		gpr_num_o = 3'h0;
		disp_o = 8'h00;
		irq_o = '0;
	end
	// One ALU request; go drops at the edge that takes it
	task automatic alu(input ccrf_op_e op, input logic word);
		@(posedge ref_clk_i);
		alu_req_o <= '{go: 1'b1, op: op, word: word};
		@(posedge ref_clk_i);
		alu_req_o <= '0;
	endtask
	// One register load, held for a single edge
	task automatic load(input ccrf_sel_e sel, input logic [15:0] d);
		@(posedge ref_clk_i);
		seq_wr_o <= '{we: 1'b1, sel: sel, data: d};
		@(posedge ref_clk_i);
		seq_wr_o <= '0;
	endtask
	// Single-cycle pointer step: 0 pc, 1 push, 2 pop
	task automatic step(input int k);
		@(posedge ref_clk_i);
		pc_inc_o <= (k == 0);
		sp_push_o <= (k == 1);
		sp_pop_o <= (k == 2);
		@(posedge ref_clk_i);
		{pc_inc_o, sp_push_o, sp_pop_o} <= 3'h0;
	endtask
	// Bank register address request
	task automatic gpr(input logic [2:0] num);
		@(posedge ref_clk_i);
		gpr_req_o <= 1'b1;
		gpr_num_o <= num;
		@(posedge ref_clk_i);
		gpr_req_o <= 1'b0;
	endtask
	// Level inputs: displacement and interrupt request
	task automatic levels(input logic [7:0] d, input logic rq, input logic [1:0] l);
		@(posedge ref_clk_i);
		disp_o <= d;
		irq_o <= '{req: rq, lvl: l};
	endtask
endmodule

// ==== bench/cpu_core_register_and_flags_bench.sv ====
`timescale 1ns/10ps
`include "ccrf_cfg.svh"
// ==========================================
// Self-checking bench of the register and flag core
module cpu_core_register_and_flags_bench
	import ccrf_pkg::*;
();
	`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin mismatches++; \
		$display("ERROR %s expected %h seen %h", nm, ex, sn); end end
	// Clock, reset and software port
	logic ref_clk_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [3:0] sw_addr = 4'h0;
	logic [15:0] sw_wdata = 16'h0000;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [15:0] rd_val;
	int mismatches = 0;
	int checked = 0;
	// Sequencer side and core outputs
	ccrf_wr_s seq_wr;
	ccrf_alu_req_s alu_req;
	ccrf_irq_s irq;
	ccrf_psw_s psw;
	ccrf_area_e area;
	logic pc_inc, sp_push, sp_pop, gpr_req, irq_take;
	logic [2:0] gpr_num;
	logic [7:0] disp;
	logic [15:0] sw_rdata, ip, acc, tmp, idx, xptr, sp, ea, gpr_addr;
	// ==========================================
	// Clock at 100 MHz
	always #5 ref_clk_i = ~ref_clk_i;
	ccrf_seq_model i_seq (.ref_clk_i(ref_clk_i), .seq_wr_o(seq_wr), .alu_req_o(alu_req),
		.pc_inc_o(pc_inc), .sp_push_o(sp_push), .sp_pop_o(sp_pop), .gpr_req_o(gpr_req),
		.gpr_num_o(gpr_num), .disp_o(disp), .irq_o(irq));
	ccrf_core i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sw_addr_i(sw_addr),
		.sw_wdata_i(sw_wdata), .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata),
		.seq_wr_i(seq_wr), .alu_req_i(alu_req), .pc_inc_i(pc_inc), .sp_push_i(sp_push),
		.sp_pop_i(sp_pop), .gpr_req_i(gpr_req), .gpr_num_i(gpr_num), .disp_i(disp),
		.irq_i(irq), .irq_take_o(irq_take), .ip_o(ip), .acc_o(acc), .tmp_o(tmp),
		.index_reg_o(idx), .extra_mem_pointer_o(xptr), .stack_top_pointer_o(sp), .psw_o(psw),
		.ea_index_o(ea), .gpr_addr_o(gpr_addr), .fetch_area_o(area));
	// ==========================================
	// Software port cycles; strobes last one cycle
	task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		sw_wr <= 1'b1;
		sw_addr <= a;
		sw_wdata <= d;
		@(posedge ref_clk_i);
		sw_wr <= 1'b0;
	endtask
	// Data is looked at only in the cycle after the strobe
	task automatic sw_read(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk_i);
		sw_rd <= 1'b1;
		sw_addr <= a;
		@(posedge ref_clk_i);
		sw_rd <= 1'b0;
		#1 d = sw_rdata;
	endtask
	// Closing report, reached once
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ==========================================
	// Values straight out of reset, unmapped read
	task automatic run_reset();
		`CHK("pc", 16'h0000, ip)
		`CHK("psw", 16'h0000, psw)
		`CHK("gpr_addr", `CCRF_BANK_BASE, gpr_addr)
		sw_read(4'hF, rd_val);
		`CHK("unmapped", 16'h0000, rd_val)
	endtask
	// Every register written and read back; rdata falls to zero after
	task automatic run_regs();
		for (int i = 0; i < 7; i++) begin
			sw_write(4'(i), 16'h1234 + 16'(i) * 16'h1111);
			sw_read(4'(i), rd_val);
			`CHK("reg", 16'h1234 + 16'(i) * 16'h1111, rd_val)
		end
		@(posedge ref_clk_i);
		#1 `CHK("rdata idle", 16'h0000, sw_rdata)
		`CHK("psw split", 16'h789A, {psw.bank, psw.cc})
		`CHK("tmp", 16'h3456, tmp)
		`CHK("index", 16'h4567, idx)
		`CHK("xptr", 16'h5678, xptr)
		sw_write(4'h9, 16'hFFFF);
		sw_read(4'h9, rd_val);
		`CHK("unmapped", 16'h0000, rd_val)
		// Sequencer load beats a software write in the same cycle
		fork
			sw_write(`CCRF_OFF_ACC, 16'h1111);
			i_seq.load(CCRF_SEL_ACC, 16'h2222);
		join
		#1 `CHK("acc load", 16'h2222, acc)
	endtask
	// Byte ALU op, then compare result and flag byte
	task automatic alu_chk(input ccrf_op_e op, input logic [15:0] ea_, input logic [7:0] ec);
		i_seq.alu(op, 1'b0);
		#1 `CHK("acc", ea_, acc)
		`CHK("flags", ec, psw.cc)
	endtask
	// Flag chain: carry out, overflow, rotate, logic and compare
	task automatic run_alu();
		sw_write(`CCRF_OFF_PSW, 16'h0000);
		sw_write(`CCRF_OFF_ACC, 16'h12F8);
		sw_write(`CCRF_OFF_TMP, 16'h0008);
		alu_chk(CCRF_OP_ADD, 16'h1200, 8'h85);
		sw_write(`CCRF_OFF_ACC, 16'h127F);
		sw_write(`CCRF_OFF_TMP, 16'h0001);
		alu_chk(CCRF_OP_ADD, 16'h1280, 8'h8A);
		alu_chk(CCRF_OP_ROLC, 16'h1200, 8'h87);
		alu_chk(CCRF_OP_AND, 16'h1200, 8'h85);
		alu_chk(CCRF_OP_CMP, 16'h1200, 8'h89);
		// Borrow in, rotate right and carry in, each from the flags left before
		alu_chk(CCRF_OP_SUBC, 16'h12FE, 8'h89);
		alu_chk(CCRF_OP_RORC, 16'h12FF, 8'h88);
		alu_chk(CCRF_OP_ADDC, 16'h1200, 8'h85);
	endtask
	// Interrupt gate over enable and level mask
	task automatic run_irq();
		logic [15:0] pv[5] = '{16'h0060, 16'h0060, 16'h0020, 16'h0070, 16'h0040};
		logic [1:0] lv[5] = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h0};
		logic ex[5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		for (int i = 0; i < 5; i++) begin
			sw_write(`CCRF_OFF_PSW, pv[i]);
			i_seq.levels(8'h00, 1'b1, lv[i]);
			#1 `CHK("irq_take", ex[i], irq_take)
		end
		i_seq.levels(8'h00, 1'b0, 2'h0);
	endtask
	// Bank address, index sum, memory areas and pointer steps
	task automatic run_addr();
		logic [15:0] pcs[3] = '{16'h0010, 16'h0200, 16'h9000};
		ccrf_area_e ar[3] = '{CCRF_AREA_IO, CCRF_AREA_DATA, CCRF_AREA_PROG};
		sw_write(`CCRF_OFF_PSW, 16'h0500);
		i_seq.gpr(3'h3);
		#1 `CHK("gpr_addr", `CCRF_BANK_BASE + 16'(5 * 8 + 3), gpr_addr)
		sw_write(`CCRF_OFF_INDEX, 16'h1000);
		i_seq.levels(8'hFE, 1'b0, 2'h0);
		repeat (2) @(posedge ref_clk_i);
		#1 `CHK("ea_index", 16'h0FFE, ea)
		for (int i = 0; i < 3; i++) begin
			sw_write(`CCRF_OFF_PC, pcs[i]);
			@(posedge ref_clk_i);
			#1 `CHK("area", ar[i], area)
		end
		i_seq.step(0);
		#1 `CHK("pc inc", 16'h9001, ip)
		sw_write(`CCRF_OFF_SP, 16'h0200);
		i_seq.step(1);
		#1 `CHK("sp push", 16'h01FF, sp)
		i_seq.step(2);
		#1 `CHK("sp pop", 16'h0200, sp)
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_b_i <= 1'b1;
		#1 run_reset();
		run_regs();
		run_alu();
		run_irq();
		run_addr();
		give_verdict();
	end
	// Guard against a hang
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		give_verdict();
	end
endmodule
